// >>> hw/stop_pulse_cfg.sv
// Purpose: Second closed-loop config word, speed pulse shaper, stop engine
// Assumes: Single AHB-Lite master; motor events are on the I_MCLK domain
// Notes:   Zero wait state slave; invalid codes fall back to safe values
`timescale 1ns/1ns
module stop_pulse_cfg
    import stop_pulse_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS  // Cycles per ms, shrink for sim
)(
    input  wire logic        I_MCLK,        // System clock 50 MHz
    input  wire logic        I_RESET,       // Async reset, high
    input  wire logic        I_HSEL,        // AHB select
    input  wire logic [31:0] I_HADDR,       // AHB address
    input  wire logic [1:0]  I_HTRANS,      // AHB transfer type
    input  wire logic        I_HWRITE,      // AHB write
    input  wire logic [2:0]  I_HSIZE,       // AHB size
    input  wire logic [31:0] I_HWDATA,      // AHB write data
    input  wire logic        I_HREADY,      // AHB bus ready
    output logic      [31:0] O_HRDATA,      // AHB read data
    output logic             O_HREADYOUT,   // AHB slave ready
    output logic             O_HRESP,       // AHB response, OKAY
    input  wire logic        I_ETICK,       // Electrical commutation tick
    input  wire logic        I_CLOSED_LOOP, // Motor in closed loop
    input  wire logic        I_FIRST_TRY,   // First start attempt running
    input  wire logic        I_DRIVEN,      // Motor being driven
    input  wire logic        I_EMF_ABOVE,   // Back-EMF above cutoff
    input  wire logic        I_STOP_REQ,    // Speed command asks for stop
    input  wire logic        I_DUTY_BELOW_S,// Duty below stop threshold
    input  wire logic        I_DUTY_BELOW_B,// Duty below brake-pin threshold
    input  wire logic        I_BRAKE_PIN,   // External brake input, async
    output logic             O_SPEED_PULSE_OUT, // Divided speed pulse
    output cfg2_s            O_CFG,         // Decoded config fields
    output logic [2:0]       O_STOP_ACTION, // Applied stop method
    output logic             O_BRAKE_LOW,   // Low side brake active
    output logic             O_SURGE_GUARD  // Anti voltage surge enable
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic [31:0] cfg, next_cfg;           // Config word
    logic        wr_pend, next_wr_pend;   // Write data phase pending
    logic [7:0]  wr_addr, next_wr_addr;   // Latched write address
    logic [31:0] rdata, next_rdata;       // Registered read data
    logic [31:0] status_word;             // Status view

    // Address phase latch and write commit
    always_comb
    begin
        next_cfg     = cfg;
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_rdata   = rdata;
        if (wr_pend && wr_addr == CFG2_OFFSET)
        begin
            // Reserved low bits stay zero
            next_cfg = I_HWDATA & CFG2_WMASK;
        end
        if (I_HSEL && I_HREADY && I_HTRANS[1])
        begin
            next_wr_pend = I_HWRITE;
            next_wr_addr = I_HADDR[7:0];
            if (I_HADDR[7:0] == CFG2_OFFSET)
                next_rdata = next_cfg;  // Sees a write landing now
            else if (I_HADDR[7:0] == STATUS_OFFSET)
                next_rdata = status_word;
            else
                next_rdata = 32'h00000000;  // Unmapped reads zero
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            cfg     <= CFG2_RESET;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            rdata   <= 32'h00000000;
        end
        else
        begin
            cfg     <= next_cfg;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            rdata   <= next_rdata;
        end
    end

    assign O_HRDATA    = rdata;
    assign O_HREADYOUT = 1'b1;   // Never waits
    assign O_HRESP     = 1'b0;   // Always OKAY

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    cfg2_s f;   // Raw field view
    assign f = cfg[30:3];
    assign O_CFG         = f;
    assign O_SURGE_GUARD = f.surge_guard_enable;

    // ------------------------------------------------------------------
    // Speed pulse divider
    // ------------------------------------------------------------------
    logic [3:0] div_ratio;   // Ticks per output toggle
    always_comb
    begin
        // Code 0 is three, C-E skip twelve
        case (f.speed_pulse_divider)
            4'h0:    div_ratio = 4'h3;
            4'hC:    div_ratio = 4'hD;
            4'hD:    div_ratio = 4'hE;
            4'hE:    div_ratio = 4'hF;
            4'hF:    div_ratio = 4'hF;  // Unlisted, held at top
            default: div_ratio = f.speed_pulse_divider;
        endcase
    end

    logic pulse_en;   // Pulses allowed now
    always_comb
    begin
        case (f.speed_pulse_mode)
            2'h0:    pulse_en = 1'b1;
            2'h1:    pulse_en = I_CLOSED_LOOP;
            2'h2:    pulse_en = I_CLOSED_LOOP | I_FIRST_TRY;
            default: pulse_en = 1'b0;   // Invalid mode, silent
        endcase
        // Activity 1 follows the drive, 0 the back-EMF; a bad cutoff mutes
        pulse_en = pulse_en & (f.speed_pulse_activity ? I_DRIVEN : I_EMF_ABOVE)
                   & (f.speed_pulse_emf_cutoff < 3'h6);
    end

    logic [3:0] tick_cnt, next_tick_cnt;   // Ticks since toggle
    logic       pulse, next_pulse;         // Output level
    always_comb
    begin
        next_tick_cnt = tick_cnt;
        next_pulse    = pulse;
        if (!pulse_en)
        begin
            next_tick_cnt = 4'h0;
            next_pulse    = 1'b0;
        end
        else if (I_ETICK)
        begin
            if (tick_cnt + 4'h1 >= div_ratio)
            begin
                next_tick_cnt = 4'h0;
                next_pulse    = ~pulse;
            end
            else
                next_tick_cnt = tick_cnt + 4'h1;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            tick_cnt <= 4'h0;
            pulse    <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            pulse    <= next_pulse;
        end
    end
    assign O_SPEED_PULSE_OUT = pulse;

    // ------------------------------------------------------------------
    // Brake pin synchroniser
    // ------------------------------------------------------------------
    logic brk_s1, brk_s2;   // Two-flop chain
    always_ff @(posedge I_MCLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            brk_s1 <= 1'b0;
            brk_s2 <= 1'b0;
        end
        else
        begin
            brk_s1 <= I_BRAKE_PIN;
            brk_s2 <= brk_s1;
        end
    end

    // ------------------------------------------------------------------
    // Stop engine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_WAIT  = 3'b010,
        ST_BRAKE = 3'b100
    } stop_state_e;

    stop_state_e state, next_state;      // Stop sequence state
    logic [13:0] hold_ms, next_hold_ms;  // Brake time in ms
    logic [16:0] ms_cnt, next_ms_cnt;    // Cycle count within a ms
    logic [13:0] ms_done, next_ms_done;  // Elapsed ms
    logic [13:0] brake_ms;   // Decoded brake duration
    always_comb
    begin
        case (f.stop_brake_duration)
            4'h0: brake_ms = 14'd1;
            4'h1: brake_ms = 14'd2;
            4'h2: brake_ms = 14'd5;
            4'h3: brake_ms = 14'd10;
            4'h4: brake_ms = 14'd15;
            4'h5: brake_ms = 14'd25;
            4'h6: brake_ms = 14'd50;
            4'h7: brake_ms = 14'd75;
            4'h8: brake_ms = 14'd100;
            4'h9: brake_ms = 14'd250;
            4'hA: brake_ms = 14'd500;
            4'hB: brake_ms = 14'd1000;
            4'hC: brake_ms = 14'd2500;
            4'hD: brake_ms = 14'd5000;
            4'hE: brake_ms = 14'd10000;
            default: brake_ms = 14'd15000;
        endcase
    end
    logic [2:0] method;   // Valid method, invalid codes act as hi-z
    assign method = (f.stop_method > 3'h4) ? 3'(STOP_HIZ) : f.stop_method;
    // Next state of the stop sequence
    always_comb
    begin
        next_state   = state;
        next_hold_ms = hold_ms;
        next_ms_cnt  = ms_cnt;
        next_ms_done = ms_done;
        case (state)
            ST_RUN:
            begin
                if (I_STOP_REQ)
                begin
                    next_state   = ST_WAIT;
                    next_hold_ms = brake_ms;
                end
            end
            ST_WAIT:
            begin
                // Code 0 means immediate, else wait for duty drop
                if (!I_STOP_REQ)
                    next_state = ST_RUN;
                else if (f.stop_brake_duty_limit == 3'h0
                         || I_DUTY_BELOW_S)
                begin
                    next_state   = ST_BRAKE;
                    next_ms_cnt  = 17'd0;
                    next_ms_done = 14'd0;
                end
            end
            ST_BRAKE:
            begin
                if (ms_cnt == 17'(MS_CYCLES - 1))
                begin
                    next_ms_cnt  = 17'd0;
                    next_ms_done = ms_done + 14'd1;
                end
                else
                    next_ms_cnt = ms_cnt + 17'd1;
                if (!I_STOP_REQ || ms_done >= hold_ms)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge I_MCLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            state   <= ST_RUN;
            hold_ms <= 14'd0;
            ms_cnt  <= 17'd0;
            ms_done <= 14'd0;
        end
        else
        begin
            state   <= next_state;
            hold_ms <= next_hold_ms;
            ms_cnt  <= next_ms_cnt;
            ms_done <= next_ms_done;
        end
    end

    // Brake pin low-side braking once duty drops below its own limit
    logic pin_brake;
    assign pin_brake = brk_s2 && (f.brake_input_duty_limit == 3'h0
                                  || I_DUTY_BELOW_B);
    assign O_STOP_ACTION = (state == ST_BRAKE) ? method
                                               : 3'(STOP_HIZ);
    assign O_BRAKE_LOW   = pin_brake ||
                           (state == ST_BRAKE && method == 3'(STOP_LOWBRK));
    // Status: state, current limit validity, low 13 bits of decoded hold time
    assign status_word = {15'h0000, (f.cycle_current_limit != 4'h0),
                          brake_ms[12:0], state};
endmodule : stop_pulse_cfg

// >>> hw/stop_pulse_pkg.sv
// Purpose: Constants and types for the stop method / speed pulse config block
// Assumes: One 32-bit configuration word reached over AHB-Lite
// Notes:   Field positions and reset values are named here only once
package stop_pulse_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  CFG2_OFFSET   = 8'h88;  // Config word
    localparam logic [7:0]  STATUS_OFFSET = 8'h8C;  // Stop engine status
    localparam logic [31:0] CFG2_RESET    = 32'h00000000;
    localparam logic [31:0] CFG2_WMASK    = 32'hFFFFFFF8; // Bits 2-0 read 0

    // ------------------------------------------------------------------
    // Field positions (low bit of each)
    // ------------------------------------------------------------------
    localparam int PARITY_POS   = 31;
    localparam int MODE_POS     = 29;
    localparam int DIV_POS      = 25;
    localparam int ACT_POS      = 24;
    localparam int EMF_POS      = 21;
    localparam int STOP_POS     = 18;
    localparam int BRK_POS      = 14;
    localparam int SDUTY_POS    = 11;
    localparam int BDUTY_POS    = 8;
    localparam int SURGE_POS    = 7;
    localparam int ILIM_POS     = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 50_000_000;
    localparam int MS_PER_S     = 1000;
    localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S; // 50000 cycles

    // Stop method encodings
    typedef enum logic [2:0] {
        STOP_HIZ    = 3'h0,
        STOP_RECIRC = 3'h1,
        STOP_LOWBRK = 3'h2,
        STOP_HIBRK  = 3'h3,
        STOP_SPIN   = 3'h4
    } stop_method_e;

    // Decoded configuration carried as one bundle
    typedef struct packed {
        logic [1:0] speed_pulse_mode;
        logic [3:0] speed_pulse_divider;
        logic       speed_pulse_activity;
        logic [2:0] speed_pulse_emf_cutoff;
        logic [2:0] stop_method;
        logic [3:0] stop_brake_duration;
        logic [2:0] stop_brake_duty_limit;
        logic [2:0] brake_input_duty_limit;
        logic       surge_guard_enable;
        logic [3:0] cycle_current_limit;
    } cfg2_s;

endpackage : stop_pulse_pkg

// >>> test/motor_stop_speed_pulse_config_tb_top.sv
// Purpose: Self-checking bench for the stop and speed pulse block
// Assumes: Zero wait slave; one ms shrunk to 5 clocks
// Notes:   Expectations come from the field tables only
`timescale 1ns/1ns
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
    fails++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module motor_stop_speed_pulse_config_tb_top import stop_pulse_pkg::*;;
    logic        clk, hready, hresp, spo, blow, surge;
    logic        rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, etick = 1'b0;
    logic        closed = 1'b0, first = 1'b0, driven = 1'b0, clr = 1'b0;
    logic        emf_hi = 1'b0, stop_req = 1'b0, dbs = 1'b0, dbb = 1'b0;
    logic        bpin = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [2:0]  act;
    logic [7:0]  seen;
    cfg2_s       cfg;
    int          fails = 0;
    int          check_count = 0;
    stop_pulse_cfg #(.MS_CYCLES(5)) stop_pulse_cfg_inst (
        .I_MCLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_ETICK(etick),
        .I_CLOSED_LOOP(closed), .I_FIRST_TRY(first), .I_DRIVEN(driven),
        .I_EMF_ABOVE(emf_hi), .I_STOP_REQ(stop_req),
        .I_DUTY_BELOW_S(dbs), .I_DUTY_BELOW_B(dbb), .I_BRAKE_PIN(bpin),
        .O_SPEED_PULSE_OUT(spo), .O_CFG(cfg), .O_STOP_ACTION(act),
        .O_BRAKE_LOW(blow), .O_SURGE_GUARD(surge));
    pulse_reader pulse_reader_inst (.i_clk(clk), .i_rst(rst),
        .i_pulse(spo), .i_clr(clr), .o_count(seen));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Single AHB transfer; sole slave's ready is the bus ready
    // Waits as long as it takes; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    function automatic logic [31:0] sw(input logic [2:0] st,
        input logic [3:0] bk, input logic [2:0] sd, bd);
        return {11'h0, st, bk, sd, bd, 8'h0};
    endfunction : sw
    // Park the shaper (mode 3 clears it), load w, then tick n times
    task automatic pulse_run(input logic [31:0] w, input logic [3:0] lv,
                             input int n);
        bus(1'b1, 32'h88, 32'h60000000, r);
        bus(1'b1, 32'h88, w, r);
        {closed, first, driven, emf_hi} <= lv;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            etick <= 1'b1;
            @(posedge clk);
            etick <= 1'b0;
        end
        repeat (3) @(negedge clk);
    endtask : pulse_run
    // Raise stop, time the brake, drop stop after lim cycles at most
    task automatic brake_len(input int lim, output logic [2:0] am,
                             output int n);
        int w;
        w = 0;
        n = 0;
        @(posedge clk);
        stop_req <= 1'b1;
        while (act === 3'h0 && w++ < 12) @(negedge clk);
        am = act;
        while (act !== 3'h0 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        stop_req <= 1'b0;
        repeat (4) @(negedge clk);
    endtask : brake_len
    task automatic t_regs();
        bus(1'b0, 32'h88, 32'h0, r);
        `CHK("reset value", 32'h0, r)
        bus(1'b0, 32'h8C, 32'h0, r);
        `CHK("status reset", 32'h00000009, r)
        bus(1'b1, 32'h88, 32'hFFFFFFFF, r);
        bus(1'b1, 32'h40, 32'h0, r);
        bus(1'b0, 32'h40, 32'h0, r);
        `CHK("unmapped", 32'h0, r)
        bus(1'b0, 32'h88, 32'h0, r);
        `CHK("all ones", 32'hFFFFFFF8, r)
        `CHK("fields", 28'hFFFFFFF, cfg)
        `CHK("surge on", 1'b1, surge)
        bus(1'b0, 32'h8C, 32'h0, r);
        `CHK("status limit", 32'h0001D4C1, r)
        bus(1'b1, 32'h88, 32'h0, r);
        bus(1'b0, 32'h88, 32'h0, r);
        `CHK("surge off", 1'b0, surge)
        $display("register test done");
    endtask : t_regs
    task automatic t_div();
        logic [3:0] c [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hB, 4'hC, 4'hE};
        int         rt;
        foreach (c[i])
        begin
            rt = (c[i] == 4'h0) ? 3 : (c[i] < 4'hC) ? c[i] : c[i] + 1;
            pulse_run({3'h0, c[i], 1'b1, 24'h0}, 4'hF, 2 * rt);
            `CHK("divide", 8'h02, seen)
        end
        $display("divider test done");
    endtask : t_div
    // Code is {mode, activity, cutoff}; lv is closed,first,driven,emf
    task automatic t_pulse();
        logic [5:0]  c [12] = '{6'h18, 6'h18, 6'h28, 6'h28, 6'h08, 6'h38,
                               6'h00, 6'h00, 6'h08, 6'h08, 6'h06, 6'h05};
        logic [3:0]  lv [12] = '{4'h3, 4'hB, 4'h7, 4'h3, 4'h3, 4'hB,
                                4'hA, 4'hB, 4'h9, 4'hA, 4'hB, 4'hB};
        logic [11:0] on = 12'hA96;
        foreach (c[i])
        begin
            pulse_run({1'b0, c[i][5:4], 4'h2, c[i][3:0], 21'h0}, lv[i], 4);
            `CHK("gate", on[i] ? 8'h02 : 8'h00, seen)
        end
        $display("pulse gating test done");
    endtask : t_pulse
    task automatic t_stop();
        logic [2:0] am, ea;
        int         n;
        @(posedge clk);
        dbs <= 1'b1;
        for (int m = 0; m < 8; m++)
        begin
            ea = (m > 0 && m < 5) ? m[2:0] : 3'h0;
            bus(1'b1, 32'h88, sw(m[2:0], 4'h0, 3'h0, 3'h0), r);
            brake_len(40, am, n);
            `CHK("method", ea, am)
            `CHK("1 ms hold", ea != 3'h0, n inside {[5:6]})
        end
        bus(1'b1, 32'h88, sw(3'h2, 4'h2, 3'h0, 3'h0), r);
        brake_len(40, am, n);
        `CHK("5 ms hold", 1'b1, n inside {[25:26]})
        bus(1'b1, 32'h88, sw(3'h3, 4'hF, 3'h0, 3'h0), r);
        brake_len(10, am, n);
        `CHK("early release", 3'h0, act)
        @(posedge clk);
        dbs <= 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, 32'h88, sw(3'h4, 4'h0, k[2:0], 3'h0), r);
            brake_len(40, am, n);
            `CHK("duty gate", (k == 0) ? 3'h4 : 3'h0, am)
        end
        $display("stop test done");
    endtask : t_stop
    task automatic t_pin();
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, 32'h88, sw(3'h0, 4'h0, 3'h0, k[2:0]), r);
            dbb <= (k == 7);
            bpin <= 1'b1;
            repeat (8) @(negedge clk);
            `CHK("pin brake", k == 0 || k == 7, blow)
            @(posedge clk);
            bpin <= 1'b0;
            repeat (8) @(negedge clk);
        end
        $display("brake pin test done");
    endtask : t_pin
    task automatic results();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_div();
        t_pulse();
        t_stop();
        t_pin();
        results();
    end
    // Whole run is about a thousand cycles; this cuts a hang short
    initial
    begin
        #(20000 * 20);
        fails++;
        results();
    end
endmodule : motor_stop_speed_pulse_config_tb_top
bind stop_pulse_cfg stop_pulse_props stop_pulse_props_inst (
    .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_HSEL(I_HSEL),
    .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .I_ETICK(I_ETICK),
    .I_STOP_REQ(I_STOP_REQ), .I_DUTY_BELOW_S(I_DUTY_BELOW_S),
    .O_SPEED_PULSE_OUT(O_SPEED_PULSE_OUT), .O_CFG(O_CFG),
    .O_STOP_ACTION(O_STOP_ACTION), .O_SURGE_GUARD(O_SURGE_GUARD));

// >>> test/pulse_reader.sv
// Purpose: Host-side reader that counts speed pulse edges
// Assumes: Pulse is a registered level on the system clock
// Notes:   Count wraps at 256, far above any test's need
`timescale 1ns/1ns
module pulse_reader (
    input  wire logic       i_clk,   // System clock
    input  wire logic       i_rst,   // Reset, high
    input  wire logic       i_pulse, // Speed pulse level
    input  wire logic       i_clr,   // Clear count
    output logic      [7:0] o_count  // Edges seen
);
    logic last;  // Pulse level one clock ago
    // Each edge is one divided electrical period
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            last    <= 1'b0;
            o_count <= 8'h00;
        end
        else
        begin
            last    <= i_pulse;
            o_count <= i_clr ? 8'h00
                             : o_count + {7'h00, i_pulse ^ last};
        end
    end
endmodule : pulse_reader

// >>> test/stop_pulse_props.sv
// Purpose: Port checks for the stop and speed pulse config block
// Assumes: One clock domain, bound to the block's top
// Notes:   Watches design outputs against their causes
`timescale 1ns/1ns
module stop_pulse_props
    import stop_pulse_pkg::*;
(
    input wire logic        I_MCLK,            // Clock
    input wire logic        I_RESET,           // Reset, high
    input wire logic        I_HSEL,            // Select
    input wire logic [31:0] I_HADDR,           // Address
    input wire logic [1:0]  I_HTRANS,          // Transfer
    input wire logic        I_HWRITE,          // Write
    input wire logic        I_HREADY,          // Bus ready
    input wire logic [31:0] O_HRDATA,          // Read data
    input wire logic        I_ETICK,           // Speed tick
    input wire logic        I_STOP_REQ,        // Stop asked
    input wire logic        I_DUTY_BELOW_S,    // Stop duty low
    input wire logic        O_SPEED_PULSE_OUT, // Pulse
    input wire cfg2_s       O_CFG,             // Fields
    input wire logic [2:0]  O_STOP_ACTION,     // Stop action
    input wire logic        O_SURGE_GUARD      // Surge guard
);
    // ------------------------------------------------------------
    // Clocking and bus decode
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    logic take;  // Address phase accepted
    assign take = I_HSEL && I_HREADY && I_HTRANS[1];
    // Readback mirrors the fields; low bits always read 0
    AST_READBACK:
    assert property (take && !I_HWRITE && I_HADDR == {24'h0, CFG2_OFFSET}
        |=> O_HRDATA[30:0] == {O_CFG, 3'h0}) else $error("readback off");
    // Fields only move two edges after a write address phase
    AST_CFG_CAUSE:
    assert property ($changed(O_CFG) |-> $past(take && I_HWRITE, 2))
        else $error("config moved without write");
    AST_SURGE:
    assert property (O_SURGE_GUARD == O_CFG.surge_guard_enable)
        else $error("surge guard not bit 7");
    // The guard pin must match bit 7 as software reads it back
    AST_SURGE_READ:
    assert property (take && !I_HWRITE && I_HADDR == {24'h0, CFG2_OFFSET}
        |=> O_HRDATA[SURGE_POS] == O_SURGE_GUARD)
        else $error("surge guard differs from readback");
    // Only codes 1-4 may act; invalid codes behave as hi-z
    AST_STOP_CODE:
    assert property (O_STOP_ACTION != 3'h0 |->
        O_STOP_ACTION == O_CFG.stop_method && O_STOP_ACTION <= 3'h4)
        else $error("bad stop action");
    AST_STOP_IDLE:
    assert property (!I_STOP_REQ [*3] |-> O_STOP_ACTION == 3'h0)
        else $error("braking without stop request");
    AST_DUTY_GATE:
    assert property ($rose(O_STOP_ACTION != 3'h0) |->
        $past(O_CFG.stop_brake_duty_limit == 3'h0 || I_DUTY_BELOW_S))
        else $error("brake began above duty limit");
    AST_MODE_BAD:
    assert property (O_CFG.speed_pulse_mode == 2'h3 [*3]
        |-> !O_SPEED_PULSE_OUT) else $error("pulse in invalid mode");
    AST_EMF_BAD:
    assert property (O_CFG.speed_pulse_emf_cutoff >= 3'h6 [*3]
        |-> !O_SPEED_PULSE_OUT) else $error("pulse with invalid cutoff");
    AST_TICK:
    assert property ($rose(O_SPEED_PULSE_OUT) |->
        $past(I_ETICK) || $past(I_ETICK, 2)) else $error("pulse w/o tick");
endmodule : stop_pulse_props
